// [hdl/sfam_pkg.sv]
/*
 * constants, field positions, reset values and the bus phase type for the
 * serial port flag and address match logic.
 * assumes an 8-bit special function register port on the system clock.
 */
// Functional notes
// - master set on start sent, cleared stop/arbitration
// - transmit mode follows start sent or data write
// - start flag set after start+address; software clears
// - stop flag set on slave stop; cleared when sent
// - ack request after received byte without hw ack
// - arbitration lost on three bus conflict cases
// - arbitration lost clears whenever interrupt clears
// - acknowledge flag captures inverted received ack bit
// - interrupt flag set by bus events; software clears
// - hw ack enable: address match and auto ack
// - mask bit one compares address bit, zero ignores
// - general call enable also accepts address zero
// - general call only counts with hw ack enabled
// - interrupt holds clock low; clear starts next event
// - mask register: mask bits 7:1 ones, enable 0
package sfam_pkg;
	// register addresses on the special function register port
	localparam logic [7:0] SFAM_CTRL_ADDR = 8'hC0;
	localparam logic [7:0] SFAM_DATA_ADDR = 8'hC2;
	localparam logic [7:0] SFAM_MASK_ADDR = 8'hCE;
	localparam logic [7:0] SFAM_ADR_ADDR  = 8'hCF;
	// values after reset
	localparam logic [7:0] SFAM_CTRL_RST  = 8'h00;
	localparam logic [7:0] SFAM_MASK_RST  = 8'hFE;
	localparam logic [7:0] SFAM_ADR_RST   = 8'h00;
	// control register bit positions
	localparam int SFAM_MASTER_BIT = 7;
	localparam int SFAM_TXMODE_BIT = 6;
	localparam int SFAM_STA_BIT    = 5;
	localparam int SFAM_STO_BIT    = 4;
	localparam int SFAM_ACKRQ_BIT  = 3;
	localparam int SFAM_ARB_BIT    = 2;
	localparam int SFAM_ACK_BIT    = 1;
	localparam int SFAM_SI_BIT     = 0;
	// mask and address register fields
	localparam int SFAM_HW_ACK_ENABLE_BIT  = 0;
	localparam int SFAM_GC_BIT     = 0;
	// bit counter: data bits per byte, then the ack bit
	localparam logic [3:0] SFAM_BYTE_BITS = 4'h8;
	localparam logic [6:0] SFAM_GEN_CALL  = 7'h00;
	// bus phase tracked by the flag block
	typedef enum logic [2:0] {
		SFAM_IDLE = 3'b001,
		SFAM_ADDR = 3'b010,
		SFAM_DATA = 3'b100
	} sfam_phase_t;
endpackage

// [hdl/sfam_flags.sv]
/*
 * status and control flags of the two-wire serial port plus hardware slave
 * address recognition and automatic acknowledge.
 * assumes the bus engine on the same clock reports start/stop generation and
 * arbitration hazards; bus pins are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
module sfam_flags
	import sfam_pkg::*;
(
	input  wire logic       I_CLK_SYS,
	input  wire logic       I_RSTN,
	input  wire logic [7:0] I_SFR_ADDR,
	input  wire logic       I_SFR_WE,
	input  wire logic [7:0] I_SFR_WDATA,
	output logic      [7:0] O_SFR_RDATA,
	input  wire logic       I_SCL_I,
	input  wire logic       I_SDA_I,
	output logic            O_SCL_O,
	output logic            O_SCL_OE,
	output logic            O_SDA_O,
	output logic            O_SDA_OE,
	input  wire logic       I_EV_START_GEN,
	input  wire logic       I_EV_STOP_GEN,
	input  wire logic       I_TRY_STOP_RS,
	input  wire logic       I_TX_ONE,
	output logic            O_START_REQ,
	output logic            O_STOP_REQ,
	output logic            O_NEXT_EVENT,
	output logic            O_ADDR_MATCH
);
	logic [1:0]  scl_sync_q;
	logic [1:0]  sda_sync_q;
	logic        scl_prev_q;
	logic        sda_prev_q;
	logic [7:0]  ctrl_q;
	logic [7:0]  mask_q;
	logic [7:0]  adr_q;
	logic [7:0]  shift_q;
	logic [3:0]  bitcnt_q;
	logic        addressed_q;
	logic        data_wr_q;
	logic        ack_drive_q;
	logic        match_q;
	logic        next_q;
	logic [7:0]  rdata_q;
	sfam_phase_t phase_q;
	logic        scl_s;
	logic        sda_s;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_det;
	logic        stop_det;
	logic        ack_bit;
	logic        byte_done;
	logic        addr_done;
	logic        match_now;
	logic        hw_ack_enable;
	logic        ctrl_wr;
	logic        si_set;
	logic        si_clr;
	logic        arb_set;
	logic        rx_ack_ok;

	// masked compare plus optional general call, only under hw ack
	function automatic logic addr_hit(input logic [6:0] rx, input logic [6:0] own,
		input logic [6:0] msk, input logic gc, input logic en);
		addr_hit = en & ((((rx ^ own) & msk) == 7'h00)
			| (gc & (rx == SFAM_GEN_CALL)));
	endfunction

	// two-flop synchronisers for the bus pins
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			scl_sync_q <= 2'b11;
			sda_sync_q <= 2'b11;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_sync_q <= {scl_sync_q[0], I_SCL_I};
			sda_sync_q <= {sda_sync_q[0], I_SDA_I};
			scl_prev_q <= scl_sync_q[1];
			sda_prev_q <= sda_sync_q[1];
		end
	end

	// bus conditions and byte boundaries
	assign scl_s     = scl_sync_q[1];
	assign sda_s     = sda_sync_q[1];
	assign scl_rise  = scl_s & ~scl_prev_q;
	assign scl_fall  = ~scl_s & scl_prev_q;
	assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
	assign ack_bit   = scl_rise & (bitcnt_q == SFAM_BYTE_BITS);
	assign byte_done = scl_rise & (bitcnt_q == SFAM_BYTE_BITS - 4'h1);
	assign addr_done = byte_done & (phase_q == SFAM_ADDR);
	assign hw_ack_enable     = mask_q[SFAM_HW_ACK_ENABLE_BIT];
	assign ctrl_wr   = I_SFR_WE & (I_SFR_ADDR == SFAM_CTRL_ADDR);
	// address bits are the first seven received, the eighth is direction
	assign match_now = addr_hit(shift_q[6:0], adr_q[7:1], mask_q[7:1],
		adr_q[SFAM_GC_BIT], hw_ack_enable);

	// bit counter, shift register and bus phase
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			bitcnt_q <= 4'h0;
			shift_q  <= 8'h00;
			phase_q  <= SFAM_IDLE;
		end else if (start_det) begin
			bitcnt_q <= 4'h0;
			phase_q  <= SFAM_ADDR;
		end else if (stop_det) begin
			bitcnt_q <= 4'h0;
			phase_q  <= SFAM_IDLE;
		end else if (scl_rise && phase_q != SFAM_IDLE) begin
			if (bitcnt_q == SFAM_BYTE_BITS) begin
				bitcnt_q <= 4'h0;
				phase_q  <= SFAM_DATA;
			end else begin
				bitcnt_q <= bitcnt_q + 4'h1;
				shift_q  <= {shift_q[6:0], sda_s};
			end
		end
	end

	// address match result and slave addressing state
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			match_q     <= 1'b0;
			addressed_q <= 1'b0;
		end else if (start_det || stop_det) begin
			match_q     <= 1'b0;
			addressed_q <= 1'b0;
		end else begin
			if (addr_done)
				match_q <= match_now & ~ctrl_q[SFAM_MASTER_BIT];
			if (ack_bit && phase_q == SFAM_ADDR && !ctrl_q[SFAM_MASTER_BIT])
				addressed_q <= ~sda_s;
		end
	end

	// hw ack drives data low over the ack bit when receiving
	assign rx_ack_ok = (phase_q == SFAM_ADDR) ? match_q : ~ctrl_q[SFAM_TXMODE_BIT]
		& ctrl_q[SFAM_ACK_BIT];
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN)
			ack_drive_q <= 1'b0;
		else if (start_det || stop_det)
			ack_drive_q <= 1'b0;
		else if (scl_fall && bitcnt_q == SFAM_BYTE_BITS)
			ack_drive_q <= hw_ack_enable & rx_ack_ok;
		else if (scl_fall)
			ack_drive_q <= 1'b0;
	end

	// data register write before a frame marks the next byte as ours to send
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN)
			data_wr_q <= 1'b0;
		else if (I_SFR_WE && I_SFR_ADDR == SFAM_DATA_ADDR)
			data_wr_q <= 1'b1;
		else if (scl_rise && bitcnt_q == 4'h0 && phase_q == SFAM_DATA)
			data_wr_q <= 1'b0;
	end

	// arbitration conflicts and interrupt sources
	assign arb_set = (start_det & ctrl_q[SFAM_MASTER_BIT] & ~ctrl_q[SFAM_STA_BIT])
		| (I_TRY_STOP_RS & ~scl_s)
		| (I_TX_ONE & scl_rise & ~sda_s & (bitcnt_q != SFAM_BYTE_BITS));
	assign si_set = I_EV_START_GEN | arb_set
		| (ack_bit & ctrl_q[SFAM_TXMODE_BIT])
		| (byte_done & ~ctrl_q[SFAM_TXMODE_BIT] & (phase_q == SFAM_DATA))
		| (addr_done & ~ctrl_q[SFAM_MASTER_BIT] & (match_now | ~hw_ack_enable))
		| (stop_det & addressed_q);
	assign si_clr = ctrl_wr & ~I_SFR_WDATA[SFAM_SI_BIT];

	// master and transmit mode indicators
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ctrl_q[SFAM_MASTER_BIT] <= SFAM_CTRL_RST[SFAM_MASTER_BIT];
			ctrl_q[SFAM_TXMODE_BIT] <= SFAM_CTRL_RST[SFAM_TXMODE_BIT];
		end else begin
			if (I_EV_START_GEN)
				ctrl_q[SFAM_MASTER_BIT] <= 1'b1;
			else if (I_EV_STOP_GEN || arb_set)
				ctrl_q[SFAM_MASTER_BIT] <= 1'b0;
			if (I_EV_START_GEN)
				ctrl_q[SFAM_TXMODE_BIT] <= 1'b1;
			else if (arb_set || (start_det && !ctrl_q[SFAM_MASTER_BIT]))
				ctrl_q[SFAM_TXMODE_BIT] <= 1'b0;
			else if (scl_rise && bitcnt_q == 4'h0 && phase_q == SFAM_DATA)
				ctrl_q[SFAM_TXMODE_BIT] <= data_wr_q;
		end
	end

	// start and stop flags; hardware sets win over software writes
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ctrl_q[SFAM_STA_BIT] <= SFAM_CTRL_RST[SFAM_STA_BIT];
			ctrl_q[SFAM_STO_BIT] <= SFAM_CTRL_RST[SFAM_STO_BIT];
		end else begin
			if (addr_done)
				ctrl_q[SFAM_STA_BIT] <= 1'b1;
			else if (ctrl_wr)
				ctrl_q[SFAM_STA_BIT] <= I_SFR_WDATA[SFAM_STA_BIT];
			if (stop_det && addressed_q)
				ctrl_q[SFAM_STO_BIT] <= 1'b1;
			else if (I_EV_STOP_GEN)
				ctrl_q[SFAM_STO_BIT] <= 1'b0;
			else if (ctrl_wr)
				ctrl_q[SFAM_STO_BIT] <= I_SFR_WDATA[SFAM_STO_BIT];
		end
	end

	// ack request, arbitration lost and acknowledge flags
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ctrl_q[SFAM_ACKRQ_BIT] <= SFAM_CTRL_RST[SFAM_ACKRQ_BIT];
			ctrl_q[SFAM_ARB_BIT]   <= SFAM_CTRL_RST[SFAM_ARB_BIT];
			ctrl_q[SFAM_ACK_BIT]   <= SFAM_CTRL_RST[SFAM_ACK_BIT];
		end else begin
			if (byte_done && !hw_ack_enable && !ctrl_q[SFAM_TXMODE_BIT])
				ctrl_q[SFAM_ACKRQ_BIT] <= 1'b1;
			else if (ack_bit)
				ctrl_q[SFAM_ACKRQ_BIT] <= 1'b0;
			if (arb_set)
				ctrl_q[SFAM_ARB_BIT] <= 1'b1;
			else if (si_clr)
				ctrl_q[SFAM_ARB_BIT] <= 1'b0;
			if (ack_bit)
				ctrl_q[SFAM_ACK_BIT] <= ~sda_s;
			else if (ctrl_wr)
				ctrl_q[SFAM_ACK_BIT] <= I_SFR_WDATA[SFAM_ACK_BIT];
		end
	end

	// interrupt flag: set wins, zero write clears and releases the bus
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ctrl_q[SFAM_SI_BIT] <= SFAM_CTRL_RST[SFAM_SI_BIT];
			next_q              <= 1'b0;
		end else begin
			if (si_set || (ctrl_wr && I_SFR_WDATA[SFAM_SI_BIT]))
				ctrl_q[SFAM_SI_BIT] <= 1'b1;
			else if (si_clr)
				ctrl_q[SFAM_SI_BIT] <= 1'b0;
			next_q <= si_clr & ~si_set;
		end
	end

	// address and mask registers
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			mask_q <= SFAM_MASK_RST;
			adr_q  <= SFAM_ADR_RST;
		end else if (I_SFR_WE) begin
			if (I_SFR_ADDR == SFAM_MASK_ADDR)
				mask_q <= I_SFR_WDATA;
			if (I_SFR_ADDR == SFAM_ADR_ADDR)
				adr_q <= I_SFR_WDATA;
		end
	end

	// registered read data; unmapped addresses read zero
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN)
			rdata_q <= 8'h00;
		else begin
			unique case (I_SFR_ADDR)
				SFAM_CTRL_ADDR: rdata_q <= ctrl_q;
				SFAM_DATA_ADDR: rdata_q <= shift_q;
				SFAM_MASK_ADDR: rdata_q <= mask_q;
				SFAM_ADR_ADDR:  rdata_q <= adr_q;
				default:        rdata_q <= 8'h00;
			endcase
		end
	end

	// outputs: clock held low while the interrupt is pending
	assign O_SFR_RDATA  = rdata_q;
	assign O_SCL_O      = 1'b0;
	assign O_SCL_OE     = ctrl_q[SFAM_SI_BIT];
	assign O_SDA_O      = 1'b0;
	assign O_SDA_OE     = ack_drive_q;
	assign O_START_REQ  = ctrl_q[SFAM_STA_BIT];
	assign O_STOP_REQ   = ctrl_q[SFAM_STO_BIT];
	assign O_NEXT_EVENT = next_q;
	assign O_ADDR_MATCH = match_q;
endmodule

// [tb/sfam_monitor.sv]
/* assertions on the flag block ports.
 * assumes one clock domain and the active low asynchronous reset. */
`timescale 1ns/1ps
module sfam_monitor
	import sfam_pkg::*;
(
	input wire logic       I_CLK_SYS,
	input wire logic       I_RSTN,
	input wire logic [7:0] I_SFR_ADDR,
	input wire logic       I_SFR_WE,
	input wire logic [7:0] I_SFR_WDATA,
	input wire logic [7:0] O_SFR_RDATA,
	input wire logic       O_SCL_O,
	input wire logic       O_SCL_OE,
	input wire logic       O_SDA_O,
	input wire logic       I_EV_STOP_GEN,
	input wire logic       O_START_REQ,
	input wire logic       O_STOP_REQ,
	input wire logic       O_NEXT_EVENT
);
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RSTN);
	// control register write strobe
	wire logic ctrl_wr = I_SFR_WE && I_SFR_ADDR == SFAM_CTRL_ADDR;
	// open drain pins only ever pull low
	chk_pins_low: assert property (
		!O_SCL_O && !O_SDA_O) else $error("bus pin driven high");
	// next event only follows a software clear, and lasts one cycle
	chk_next_cause: assert property (
		O_NEXT_EVENT |-> $past(ctrl_wr && !I_SFR_WDATA[0])) else $error("next event without clear");
	chk_next_pulse: assert property (
		O_NEXT_EVENT |=> !O_NEXT_EVENT) else $error("next event too long");
	chk_clear_release: assert property (
		ctrl_wr && !I_SFR_WDATA[0] && O_SCL_OE |=> O_NEXT_EVENT != O_SCL_OE)
		else $error("clear did not release clock");
	chk_force_irq: assert property (
		ctrl_wr && I_SFR_WDATA[0] |=> O_SCL_OE) else $error("forced interrupt missing");
	// start flag left alone by hardware, stop flag cleared once sent
	chk_start_hold: assert property (
		O_START_REQ && !(ctrl_wr && !I_SFR_WDATA[5]) |=> O_START_REQ)
		else $error("start flag cleared by hardware");
	chk_stop_done: assert property (
		O_STOP_REQ && I_EV_STOP_GEN && !ctrl_wr |=> !O_STOP_REQ) else $error("stop flag stuck");
	// arbitration and interrupt bits read back clear after a clear
	chk_arb_clear: assert property (
		O_NEXT_EVENT && I_SFR_ADDR == SFAM_CTRL_ADDR && !I_SFR_WE |=> (O_SFR_RDATA & 8'h05) == 8'h00)
		else $error("arbitration flag not cleared");
endmodule
bind sfam_flags sfam_monitor sfam_monitor_i (.*);

// [tb/sfam_bus_model.sv]
/* second master on the two-wire bus, open drain, 32 ns bit clock.
 * assumes the bench resolves both wires with pull-ups. */
`timescale 1ns/1ps
module sfam_bus_model (
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_low,
	output logic      sda_low
);
	// bus released, clock still outside frames
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	// one clock high phase, waiting out a stretched low
	task automatic pulse(output logic s);
		scl_low = 1'b0;
		repeat (400) if (!scl) #1;
		#8;
		s = sda;
		#8;
		scl_low = 1'b1;
		#8;
	endtask
	// start, then address and direction msb first; clock left low
	task automatic frame(input logic [7:0] b);
		logic s;
		sda_low = 1'b1;
		#16;
		scl_low = 1'b1;
		#8;
		for (int i = 7; i >= 0; i--) begin
			sda_low = !b[i];
			#8;
			pulse(s);
		end
		sda_low = 1'b0;
	endtask
	// ninth bit, low level counts as acknowledge
	task automatic ack(output logic a);
		logic s;
		#8;
		pulse(s);
		a = !s;
	endtask
	// data rises while the clock is high
	task automatic stop();
		sda_low = 1'b1;
		#8;
		scl_low = 1'b0;
		#16;
		sda_low = 1'b0;
		#16;
	endtask
endmodule

// [tb/smbus_flags_addr_match_tb_top.sv]
/* self-checking bench: registers, master flags, arbitration, address match.
 * assumes the flag block and the bus model on a 250 MHz clock. */
`timescale 1ns/1ps
module smbus_flags_addr_match_tb_top;
	import sfam_pkg::*;
	logic       clk = 1'b0, rstn = 1'b0, we = 1'b0, stg = 1'b0, spg = 1'b0, tr = 1'b0;
	logic       tx1 = 1'b0;
	logic [7:0] adr = 8'h00, wd = 8'h00, rdat, v;
	logic       scl_oe, scl_o, sda_oe, sda_o, sreq, preq, nev, mtc, m_scl, m_sda, a;
	logic       h, g, mt;
	logic [6:0] mk, ad, sa;
	int         miscompares = 0, checks = 0;
	// {hw ack, mask, own address, general call, sent address, expect match}
	localparam logic [23:0] TBL [8] = '{
		{1'b1, 7'h7F, 7'h34, 1'b0, 7'h34, 1'b1}, {1'b1, 7'h7F, 7'h34, 1'b0, 7'h35, 1'b0},
		{1'b1, 7'h7F, 7'h34, 1'b1, 7'h00, 1'b1}, {1'b1, 7'h7F, 7'h34, 1'b0, 7'h00, 1'b0},
		{1'b1, 7'h7E, 7'h34, 1'b0, 7'h35, 1'b1}, {1'b1, 7'h73, 7'h70, 1'b0, 7'h7C, 1'b1},
		{1'b1, 7'h73, 7'h70, 1'b0, 7'h71, 1'b0}, {1'b0, 7'h7F, 7'h00, 1'b1, 7'h00, 1'b0}};
	// wired-and bus levels with pull-ups
	wire logic scl = !(m_scl || (scl_oe && !scl_o));
	wire logic sda = !(m_sda || (sda_oe && !sda_o));
	always #2 clk = !clk;
	sfam_flags sfam_flags_i (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_SFR_ADDR(adr), .I_SFR_WE(we),
		.I_SFR_WDATA(wd), .O_SFR_RDATA(rdat), .I_SCL_I(scl), .I_SDA_I(sda), .O_SCL_O(scl_o),
		.O_SCL_OE(scl_oe), .O_SDA_O(sda_o), .O_SDA_OE(sda_oe), .I_EV_START_GEN(stg),
		.I_EV_STOP_GEN(spg), .I_TRY_STOP_RS(tr), .I_TX_ONE(tx1), .O_START_REQ(sreq),
		.O_STOP_REQ(preq), .O_NEXT_EVENT(nev), .O_ADDR_MATCH(mtc));
	sfam_bus_model sfam_bus_model_i (.scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda));
	// compare one value and count it
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		checks++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	// register port write and read
	task automatic wr(input logic [7:0] ra, input logic [7:0] d);
		@(negedge clk) {adr, wd, we} = {ra, d, 1'b1};
		@(negedge clk) we = 1'b0;
	endtask
	task automatic rd(input logic [7:0] ra, output logic [7:0] d);
		@(negedge clk) adr = ra;
		@(negedge clk) d = rdat;
	endtask
	task automatic rc(input logic [7:0] e, input logic [7:0] m);
		rd(SFAM_CTRL_ADDR, v);
		chk("ctrl", e, v & m);
	endtask
	task automatic final_report();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// watchdog
	initial begin
		#100000;
		miscompares++;
		final_report();
	end
	initial begin
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		rd(SFAM_MASK_ADDR, v);
		chk("mask", 8'hFE, v);
		rd(SFAM_ADR_ADDR, v);
		chk("address", 8'h00, v);
		rd(8'h10, v);
		chk("unmapped", 8'h00, v);
		rc(8'h00, 8'hFF);
		// software may force the interrupt and then clear it
		wr(SFAM_CTRL_ADDR, 8'h01);
		rc(8'h01, 8'hFF);
		wr(SFAM_CTRL_ADDR, 8'h00);
		rc(8'h00, 8'h01);
		$display("test registers done");
		@(negedge clk) stg = 1'b1;
		@(negedge clk) stg = 1'b0;
		rc(8'hC1, 8'hFF);
		chk("scl hold", 8'h01, {7'h00, scl_oe});
		wr(SFAM_CTRL_ADDR, 8'h10);
		chk("stop req", 8'h01, {7'h00, preq});
		@(negedge clk) spg = 1'b1;
		@(negedge clk) spg = 1'b0;
		rc(8'h00, 8'h90);
		$display("test master done");
		@(negedge clk) stg = 1'b1;
		@(negedge clk) stg = 1'b0;
		wr(SFAM_CTRL_ADDR, 8'h00);
		sfam_bus_model_i.scl_low = 1'b1;
		tr = 1'b1;
		repeat (8) @(negedge clk);
		tr = 1'b0;
		sfam_bus_model_i.scl_low = 1'b0;
		rc(8'h05, 8'h85);
		wr(SFAM_CTRL_ADDR, 8'h00);
		rc(8'h00, 8'h05);
		// a one is driven while the far side holds data low at a clock rise
		sfam_bus_model_i.scl_low = 1'b1;
		repeat (4) @(negedge clk);
		sfam_bus_model_i.sda_low = 1'b1;
		tx1 = 1'b1;
		repeat (4) @(negedge clk);
		sfam_bus_model_i.scl_low = 1'b0;
		repeat (8) @(negedge clk);
		tx1 = 1'b0;
		sfam_bus_model_i.sda_low = 1'b0;
		rc(8'h05, 8'h85);
		wr(SFAM_CTRL_ADDR, 8'h00);
		rc(8'h00, 8'h05);
		// repeated start seen while master with the start flag low
		@(negedge clk) stg = 1'b1;
		@(negedge clk) stg = 1'b0;
		wr(SFAM_CTRL_ADDR, 8'h00);
		repeat (4) @(negedge clk);
		sfam_bus_model_i.sda_low = 1'b1;
		repeat (8) @(negedge clk);
		sfam_bus_model_i.sda_low = 1'b0;
		rc(8'h05, 8'hC5);
		wr(SFAM_CTRL_ADDR, 8'h00);
		rc(8'h00, 8'h05);
		$display("test arbitration done");
		// one address frame per table row, then ack and stop
		for (int i = 0; i < 8; i++) begin
			{h, mk, ad, g, sa, mt} = TBL[i];
			wr(SFAM_MASK_ADDR, {mk, h});
			wr(SFAM_ADR_ADDR, {ad, g});
			sfam_bus_model_i.frame({sa, 1'b0});
			repeat (10) @(negedge clk);
			rc({4'h2, !h, 2'b00, mt || !h}, 8'hFF);
			chk("match", {7'h00, mt}, {7'h00, mtc});
			rd(SFAM_DATA_ADDR, v);
			chk("data", {sa, 1'b0}, v);
			wr(SFAM_CTRL_ADDR, 8'h00);
			sfam_bus_model_i.ack(a);
			chk("ack", {7'h00, mt}, {7'h00, a});
			repeat (10) @(negedge clk);
			rc({6'h00, mt, 1'b0}, 8'hFF);
			sfam_bus_model_i.stop();
			repeat (10) @(negedge clk);
			rc({3'b000, mt, 2'b00, mt, mt}, 8'hFF);
			wr(SFAM_CTRL_ADDR, 8'h00);
		end
		$display("test address match done");
		final_report();
	end
endmodule
